// File: peb_cfg.svh
`ifndef PEB_CFG_SVH
`define PEB_CFG_SVH
// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PEB_MEM_AW        19
`define PEB_DW            16
`define PEB_EXP_AW        3
`define PEB_IRQ_LOW_W     2
`define PEB_IRQ_TRIO_W    3
// ----------------------------------------------------------------------------
// Reset qualification
// ----------------------------------------------------------------------------
`define PEB_RST_EDGES     3'h4
// ----------------------------------------------------------------------------
// Extended cycle: extra low phases added to a processor cycle
// ----------------------------------------------------------------------------
`define PEB_EXT_PHASES    2'h1
// ----------------------------------------------------------------------------
// Processor clock low level after reset, and output reset levels
// ----------------------------------------------------------------------------
`define PEB_PCLK_RST      1'h0
`define PEB_STROBE_RST    1'h1
`endif

// File: peb_pkg.sv
package peb_pkg;
  `include "peb_cfg.svh"
  typedef enum logic [1:0] {
    PEB_ACC_NONE,
    PEB_ACC_READ,
    PEB_ACC_WRITE
  } peb_acc_e;
  typedef enum logic [1:0] {
    PEB_PH_HIGH,
    PEB_PH_LOW,
    PEB_PH_EXT
  } peb_phase_e;
  typedef logic [`PEB_DW-1:0] peb_word_t;
endpackage

// File: peb_sync_edge.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Sample on enable, flag rising edge between samples
// ----------------------------------------------------------------------------
module peb_sync_edge (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic smp_en,
  input  wire logic din,
  output logic      level_ff,
  output logic      rise_ff
);
  logic prev_ff;
  wire  rise_now = din & ~prev_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_ff  <= 1'b0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      prev_ff <= din;
      if (smp_en) begin
        level_ff <= din;
        rise_ff  <= rise_now;
      end else if (rise_now) begin
        rise_ff <= 1'b1;
      end
    end
  end
endmodule

// File: peb_top.sv
`timescale 1ns/1ps
`include "peb_cfg.svh"
// Operation
// [R1] Five external requests sampled high on rising pclk
// [R2] Requests three to five also feed timers
// [R3] Non-maskable request caught on rising edge
// [R4] Suppress input blocks maskable requests only
// [R5] Drive three-bit expansion address bus
// [R6] Drive nineteen-bit main memory word address
// [R7] Expansion data: device writes, peripheral reads
// [R8] Memory data: device writes, memory reads
// [R9] Extend cycles for user access, expansion reads
// [R10] Stretch expansion strobe for extended reads
// [R11] Reset taken after four held edges
// [R12] Shorter reset pulses are ignored
// [R13] Both byte selects low only without access; code also drops both for an access with core_byte_en 2'b00
// [R14] Drive memory data during streamed instructions
// [R15] Strobe stays high for on-chip expansion cycles
// [R16] Expansion writes pull write low, drive data
// [R17] Expansion data released outside write cycles
// [R18] Processor clock half rate, held by wait
// [R19] Strobe low during external expansion operation
// [R20] Byte selects follow accessed data halves
// [R21] Memory write low only during memory writes
module peb_top
  import peb_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      reset_in,
  input  wire logic                      wait_in,
  input  wire logic                      user_cycle_extend_bit,
  input  wire logic                      expansion_read_extend_bit,
  input  wire logic [`PEB_IRQ_LOW_W-1:0] ext_irq_low_pair,
  input  wire logic [`PEB_IRQ_TRIO_W-1:0] ext_irq_dual_use_trio,
  input  wire logic                      nmi_in,
  input  wire logic                      nmi_mode0,
  input  wire logic                      maskable_irq_block_in,
  input  wire peb_acc_e                  core_mem_acc,
  input  wire logic                      core_mem_user,
  input  wire logic                      core_streamed,
  input  wire logic [`PEB_MEM_AW-1:0]    core_mem_addr,
  input  wire logic [1:0]                core_byte_en,
  input  wire peb_word_t                 core_mem_wdata,
  input  wire peb_acc_e                  core_exp_acc,
  input  wire logic                      core_exp_internal,
  input  wire logic [`PEB_EXP_AW-1:0]    core_exp_addr,
  input  wire peb_word_t                 core_exp_wdata,
  input  wire peb_word_t                 main_mem_data_in,
  input  wire peb_word_t                 expansion_data_in,
  output logic                           core_reset_ff,
  output logic                           pclk_ff,
  output logic                           cycle_start_ff,
  output logic [`PEB_MEM_AW-1:0]         main_mem_word_addr,
  output peb_word_t                      main_mem_data_out,
  output logic                           main_mem_data_oe,
  output logic                           memory_write_n,
  output logic                           high_byte_select,
  output logic                           low_byte_select,
  output logic [`PEB_EXP_AW-1:0]         expansion_addr_bus,
  output peb_word_t                      expansion_data_out,
  output logic                           expansion_data_oe,
  output logic                           expansion_strobe_n,
  output logic                           expansion_write_n,
  output peb_word_t                      mem_rdata_ff,
  output peb_word_t                      exp_rdata_ff,
  output logic [4:0]                     irq_level_ff,
  output logic                           nmi_req_ff,
  output logic [`PEB_IRQ_TRIO_W-1:0]     timer_trig_ff
);
  // --------------------------------------------------------------------------
  // Reset qualification
  // --------------------------------------------------------------------------
  logic [2:0] rst_cnt_ff;
  wire        rst_held = (rst_cnt_ff >= (`PEB_RST_EDGES - 3'h1));
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_cnt_ff    <= 3'h0;
      core_reset_ff <= 1'b1;
    end else if (reset_in) begin
      if (!rst_held) begin
        rst_cnt_ff <= rst_cnt_ff + 3'h1;
      end
      core_reset_ff <= core_reset_ff | rst_held; // [R11]
    end else begin
      rst_cnt_ff    <= 3'h0; // [R12]
      core_reset_ff <= 1'b0;
    end
  end
  wire run = ~core_reset_ff;

  // --------------------------------------------------------------------------
  // Processor clock: half rate, low phase held by wait or extension
  // --------------------------------------------------------------------------
  peb_phase_e ph_ff;
  logic       ext_done_ff;
  wire        mem_ext  = (core_mem_acc != PEB_ACC_NONE) & core_mem_user & user_cycle_extend_bit;
  wire        exp_rd_x = (core_exp_acc == PEB_ACC_READ) & ~core_exp_internal
                         & expansion_read_extend_bit;
  wire        need_ext = (mem_ext | exp_rd_x) & ~ext_done_ff; // [R9]
  wire        go_high  = (ph_ff != PEB_PH_HIGH) & ~wait_in & ~need_ext; // [R18]
  wire        cyc_go   = run & go_high;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      ph_ff          <= PEB_PH_LOW;
      pclk_ff        <= `PEB_PCLK_RST;
      ext_done_ff    <= 1'b0;
      cycle_start_ff <= 1'b0;
    end else begin
      cycle_start_ff <= go_high;
      unique case (ph_ff)
        PEB_PH_HIGH: begin
          ph_ff   <= PEB_PH_LOW;
          pclk_ff <= 1'b0;
        end
        PEB_PH_LOW, PEB_PH_EXT: begin
          if (go_high) begin
            ph_ff       <= PEB_PH_HIGH;
            pclk_ff     <= 1'b1;
            ext_done_ff <= 1'b0;
          end else if (need_ext) begin
            ph_ff       <= PEB_PH_EXT;
            ext_done_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt inputs
  // --------------------------------------------------------------------------
  wire [4:0] irq_raw = {ext_irq_dual_use_trio, ext_irq_low_pair};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_level_ff <= 5'h00;
    end else if (cyc_go) begin
      irq_level_ff <= irq_raw & {5{~maskable_irq_block_in}}; // [R1] [R4]
    end
  end

  logic nmi_rise;
  peb_sync_edge u_nmi (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .smp_en   (cyc_go | (nmi_mode0 & run)),
    .din      (nmi_in),
    .level_ff (),
    .rise_ff  (nmi_rise)
  );
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nmi_req_ff <= 1'b0;
    end else begin
      nmi_req_ff <= nmi_rise; // [R3]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PEB_IRQ_TRIO_W; gi++) begin : g_trig
      logic trig;
      peb_sync_edge u_trig (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .smp_en   (1'b1),
        .din      (ext_irq_dual_use_trio[gi]),
        .level_ff (),
        .rise_ff  (trig)
      );
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          timer_trig_ff[gi] <= 1'b0;
        end else begin
          timer_trig_ff[gi] <= trig; // [R2]
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Main memory bus
  // --------------------------------------------------------------------------
  wire mem_any  = run & (core_mem_acc != PEB_ACC_NONE);
  wire mem_wr   = run & (core_mem_acc == PEB_ACC_WRITE);
  wire mem_drv  = mem_wr | (run & core_streamed & ~mem_any); // [R8] [R14]
  // Selects drop together for a streamed cycle without access, or for an access with core_byte_en 2'b00
  wire idle_sel = ~(run & core_streamed); // [R13]
  wire nxt_hsel = mem_any ? core_byte_en[1] : idle_sel; // [R20]
  wire nxt_lsel = mem_any ? core_byte_en[0] : idle_sel; // [R13]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      main_mem_word_addr <= '0;
      main_mem_data_out  <= '0;
      main_mem_data_oe   <= 1'b0;
      memory_write_n     <= 1'b1;
      high_byte_select   <= 1'b1;
      low_byte_select    <= 1'b1;
      mem_rdata_ff       <= '0;
    end else begin
      main_mem_word_addr <= core_mem_addr; // [R6]
      main_mem_data_out  <= core_mem_wdata;
      main_mem_data_oe   <= mem_drv;
      memory_write_n     <= ~mem_wr; // [R21]
      high_byte_select   <= nxt_hsel;
      low_byte_select    <= nxt_lsel;
      if (cyc_go && core_mem_acc == PEB_ACC_READ) begin
        mem_rdata_ff <= main_mem_data_in;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Expansion bus
  // --------------------------------------------------------------------------
  wire exp_any  = run & (core_exp_acc != PEB_ACC_NONE);
  wire exp_wr   = run & (core_exp_acc == PEB_ACC_WRITE);
  wire nxt_stb  = ~(exp_any & ~core_exp_internal); // [R15] [R19] [R10]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      expansion_addr_bus <= '0;
      expansion_data_out <= '0;
      expansion_data_oe  <= 1'b0;
      expansion_strobe_n <= `PEB_STROBE_RST;
      expansion_write_n  <= 1'b1;
      exp_rdata_ff       <= '0;
    end else begin
      expansion_addr_bus <= core_exp_addr; // [R5]
      expansion_data_out <= core_exp_wdata;
      expansion_data_oe  <= exp_wr; // [R7] [R16] [R17]
      expansion_write_n  <= ~exp_wr;
      expansion_strobe_n <= nxt_stb;
      if (cyc_go && core_exp_acc == PEB_ACC_READ && !core_exp_internal) begin
        exp_rdata_ff <= expansion_data_in;
      end
    end
  end
endmodule

// File: peb_chk.sv
`timescale 1ns/1ps
module peb_chk
  import peb_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       reset_in,
  input wire logic       core_reset_ff,
  input wire logic       pclk_ff,
  input wire peb_acc_e   core_exp_acc,
  input wire peb_acc_e   core_mem_acc,
  input wire logic       core_exp_internal,
  input wire logic       core_streamed,
  input wire logic       expansion_strobe_n,
  input wire logic       expansion_write_n,
  input wire logic       expansion_data_oe,
  input wire logic       memory_write_n,
  input wire logic       high_byte_select,
  input wire logic       low_byte_select,
  input wire logic [1:0] core_byte_en,
  input wire logic [2:0] ext_irq_dual_use_trio,
  input wire logic [2:0] timer_trig_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence held4_s;
    reset_in [*4];
  endsequence
  sequence ext_wr_s;
    core_exp_acc == PEB_ACC_WRITE && !core_reset_ff;
  endsequence
  rst_taken_a: assert property (held4_s |-> ##[1:2] core_reset_ff)
    else $error("held reset not taken");
  rst_short_a: assert property ($rose(core_reset_ff) |->
    $past(reset_in, 2) && $past(reset_in, 3) && $past(reset_in, 4)) else $error("short reset taken");
  strobe_onchip_a: assert property (core_exp_internal |=> expansion_strobe_n)
    else $error("strobe low on on-chip cycle");
  exp_write_a: assert property (ext_wr_s |=> !expansion_write_n && expansion_data_oe)
    else $error("expansion write not driven");
  exp_release_a: assert property (expansion_data_oe |->
    $past(core_exp_acc) == PEB_ACC_WRITE && !$past(core_reset_ff))
    else $error("expansion data driven outside write");
  strobe_ext_a: assert property (core_exp_acc == PEB_ACC_READ && !core_exp_internal
    && !core_reset_ff |=> !expansion_strobe_n) else $error("strobe high on external read");
  byte_sel_a: assert property (core_mem_acc != PEB_ACC_NONE && !core_reset_ff |=>
    {high_byte_select, low_byte_select} == $past(core_byte_en)) else $error("byte select wrong");
  mem_write_a: assert property (!memory_write_n |-> $past(core_mem_acc) == PEB_ACC_WRITE)
    else $error("memory write low without write");
  pclk_high_a: assert property (pclk_ff |=> !pclk_ff)
    else $error("processor clock high too long");
  sel_idle_a: assert property (core_mem_acc == PEB_ACC_NONE && !core_streamed |=>
    high_byte_select && low_byte_select) else $error("byte selects low outside streaming");
  trig_edge_a: assert property ($rose(ext_irq_dual_use_trio[0]) |-> ##2 timer_trig_ff[0])
    else $error("timer trigger missed");
endmodule
bind peb_top peb_chk u_chk (.core_clk, .rst_n, .reset_in, .core_reset_ff, .pclk_ff,
  .core_exp_acc, .core_mem_acc, .core_exp_internal, .core_streamed, .expansion_strobe_n,
  .expansion_write_n, .expansion_data_oe, .memory_write_n, .high_byte_select,
  .low_byte_select, .core_byte_en, .ext_irq_dual_use_trio, .timer_trig_ff);

// File: peb_far_model.sv
`timescale 1ns/1ps
module peb_far_model
  import peb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [18:0] main_mem_word_addr,
  input  wire peb_word_t   main_mem_data_out,
  input  wire peb_word_t   expansion_data_out,
  input  wire logic        main_mem_data_oe,
  input  wire logic        memory_write_n,
  input  wire logic        high_byte_select,
  input  wire logic        low_byte_select,
  input  wire logic [2:0]  expansion_addr_bus,
  input  wire logic        expansion_data_oe,
  input  wire logic        expansion_strobe_n,
  input  wire logic        expansion_write_n,
  output peb_word_t        main_mem_data_in,
  output peb_word_t        expansion_data_in
);
  peb_word_t mem [16];
  peb_word_t dev [8];
  peb_word_t last_md = 16'h0000;
  wire logic mem_rd = memory_write_n && (high_byte_select || low_byte_select);
  // Released memory bus with both byte selects low shows a changing pattern, never the last value
  assign main_mem_data_in = main_mem_data_oe ? main_mem_data_out
    : mem_rd ? mem[main_mem_word_addr[3:0]] : ~last_md;
  // Pull-ups hold the expansion lines high when nobody drives
  assign expansion_data_in = expansion_data_oe ? expansion_data_out
    : !expansion_strobe_n ? dev[expansion_addr_bus] : 16'hFFFF;
  initial foreach (dev[i]) dev[i] = 16'h0000;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  always @(posedge core_clk) begin
    last_md <= main_mem_data_in;
    if (!memory_write_n && high_byte_select) mem[main_mem_word_addr[3:0]][15:8] <= main_mem_data_out[15:8];
    if (!memory_write_n && low_byte_select) mem[main_mem_word_addr[3:0]][7:0] <= main_mem_data_out[7:0];
    if (!expansion_strobe_n && !expansion_write_n) dev[expansion_addr_bus] <= expansion_data_out;
  end
endmodule

// File: peb_top_tb.sv
`timescale 1ns/1ps
module peb_top_tb;
  import peb_pkg::*;
  typedef struct {peb_acc_e acc; logic intn; logic [2:0] a; peb_word_t d; logic [2:0] p;
    peb_word_t rd;} peb_row_s;
  logic core_clk, rst_n, reset_in, wait_in, user_cycle_extend_bit, expansion_read_extend_bit;
  logic nmi_in, nmi_mode0, maskable_irq_block_in, core_mem_user, core_streamed, core_exp_internal;
  logic [1:0] ext_irq_low_pair, core_byte_en;
  logic [2:0] ext_irq_dual_use_trio, core_exp_addr, expansion_addr_bus, timer_trig_ff;
  logic [18:0] core_mem_addr, main_mem_word_addr;
  peb_acc_e core_mem_acc, core_exp_acc;
  peb_word_t core_mem_wdata, core_exp_wdata, main_mem_data_in, expansion_data_in;
  peb_word_t main_mem_data_out, expansion_data_out, mem_rdata_ff, exp_rdata_ff;
  logic core_reset_ff, pclk_ff, cycle_start_ff, main_mem_data_oe, memory_write_n, nmi_req_ff;
  logic high_byte_select, low_byte_select, expansion_data_oe, expansion_strobe_n, expansion_write_n;
  logic [4:0] irq_level_ff;
  logic [3:0] seen;
  int n_fail, total_checks, n;
  peb_row_s rows[5] = '{'{PEB_ACC_WRITE, 0, 3'h3, 16'hA5A5, 3'b001, 16'h0000},
    '{PEB_ACC_READ, 0, 3'h3, 16'h0000, 3'b010, 16'hA5A5},
    '{PEB_ACC_WRITE, 1, 3'h5, 16'h5A5A, 3'b101, 16'h0000},
    '{PEB_ACC_READ, 1, 3'h5, 16'h0000, 3'b110, 16'h0000},
    '{PEB_ACC_READ, 0, 3'h6, 16'h0000, 3'b010, 16'h0000}};
  peb_top DUT (.*);
  peb_far_model u_far (.*);
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic hold(int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic chk(string nm, logic [18:0] sv, logic [18:0] ev);
    total_checks++;
    if (sv !== ev) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic per(output int k);
    for (int i = 0; i < 40 && cycle_start_ff !== 1'b1; i++) hold(1);
    k = 0;
    do begin hold(1); k++; end while (cycle_start_ff !== 1'b1 && k < 40);
    if (k >= 40) begin n_fail++; report_and_stop(); end
  endtask
  task automatic mem(peb_acc_e acc, logic [1:0] be, peb_word_t d);
    core_mem_acc = acc;
    core_byte_en = be;
    core_mem_wdata = d;
    hold(5);
  endtask
  task automatic watch();
    seen = 4'h0;
    repeat (10) begin hold(1); seen |= {timer_trig_ff, nmi_req_ff}; end
  endtask
  initial begin
    {reset_in, wait_in, user_cycle_extend_bit, expansion_read_extend_bit, nmi_in} = '0;
    {nmi_mode0, maskable_irq_block_in, core_mem_user, core_streamed, core_exp_internal} = '0;
    {ext_irq_low_pair, ext_irq_dual_use_trio, core_byte_en, core_exp_addr} = '0;
    {core_mem_wdata, core_exp_wdata, n_fail, total_checks} = '0;
    core_mem_acc = PEB_ACC_NONE;
    core_exp_acc = PEB_ACC_NONE;
    core_mem_addr = 19'h12345;
    rst_n = 0;
    hold(6);
    chk("reset levels", {core_reset_ff, pclk_ff, expansion_strobe_n, expansion_write_n,
      memory_write_n, high_byte_select, low_byte_select, expansion_data_oe,
      main_mem_data_oe}, 9'h17C);
    rst_n = 1;
    hold(2);
    foreach (rows[i]) begin
      core_exp_acc = rows[i].acc;
      {core_exp_internal, core_exp_addr, core_exp_wdata} = {rows[i].intn, rows[i].a, rows[i].d};
      hold(5);
      chk("exp pins", {expansion_strobe_n, expansion_write_n, expansion_data_oe}, rows[i].p);
      chk("exp addr", expansion_addr_bus, rows[i].a);
      if (rows[i].p[0]) chk("exp wdata", expansion_data_out, rows[i].d);
      if (rows[i].p == 3'b010) chk("exp rdata", exp_rdata_ff, rows[i].rd);
      core_exp_acc = PEB_ACC_NONE;
      hold(3);
      chk("exp idle", {expansion_strobe_n, expansion_data_oe}, 2'b10);
    end
    $display("test expansion done");
    mem(PEB_ACC_WRITE, 2'b11, 16'h1234);
    chk("mem pins", {memory_write_n, high_byte_select, low_byte_select}, 3'b011);
    chk("mem addr", main_mem_word_addr, 19'h12345);
    chk("mem wdata", {main_mem_data_oe, main_mem_data_out}, {1'b1, 16'h1234});
    mem(PEB_ACC_WRITE, 2'b01, 16'hBEEF);
    chk("mem sel", {high_byte_select, low_byte_select}, 2'b01);
    mem(PEB_ACC_READ, 2'b11, 16'h0000);
    chk("mem rd", {memory_write_n, main_mem_data_oe, mem_rdata_ff}, {2'b10, 16'h12EF});
    core_streamed = 1;
    mem(PEB_ACC_NONE, 2'b00, 16'hC3C3);
    chk("streamed sel", {high_byte_select, low_byte_select}, 2'b00);
    chk("streamed bus", {main_mem_data_oe, main_mem_data_out}, {1'b1, 16'hC3C3});
    core_streamed = 0;
    hold(2);
    chk("idle sel", {high_byte_select, low_byte_select}, 2'b11);
    $display("test memory done");
    per(n);
    chk("pclk normal", n, 2);
    {user_cycle_extend_bit, core_mem_user} = 2'b11;
    core_mem_acc = PEB_ACC_READ;
    hold(2);
    per(n);
    chk("pclk user ext", n, 3);
    {user_cycle_extend_bit, core_mem_user} = 2'b00;
    core_mem_acc = PEB_ACC_NONE;
    expansion_read_extend_bit = 1'b1;
    core_exp_acc = PEB_ACC_READ;
    hold(2);
    per(n);
    chk("pclk read ext", n, 3);
    chk("strobe stretched", expansion_strobe_n, 1'b0);
    {expansion_read_extend_bit, wait_in} = 2'b01;
    core_exp_acc = PEB_ACC_NONE;
    hold(6);
    chk("pclk wait", {pclk_ff, cycle_start_ff}, 2'b00);
    wait_in = 0;
    $display("test cycle done");
    {ext_irq_dual_use_trio, ext_irq_low_pair} = 5'b10111;
    watch();
    chk("timer trig", seen[3:1], 3'b101);
    chk("irq level", irq_level_ff, 5'b10111);
    maskable_irq_block_in = 1;
    hold(6);
    chk("irq blocked", irq_level_ff, 5'b00000);
    {nmi_mode0, nmi_in} = 2'b11;
    watch();
    chk("nmi seen", seen[0], 1'b1);
    {nmi_mode0, nmi_in} = 2'b00;
    hold(2);
    nmi_in = 1;
    watch();
    chk("nmi sampled", seen[0], 1'b1);
    {maskable_irq_block_in, nmi_in, ext_irq_dual_use_trio, ext_irq_low_pair} = '0;
    $display("test interrupt done");
    reset_in = 1;
    hold(3);
    reset_in = 0;
    hold(3);
    chk("short reset", core_reset_ff, 1'b0);
    reset_in = 1;
    core_exp_acc = PEB_ACC_WRITE;
    hold(5);
    chk("long reset", {core_reset_ff, expansion_strobe_n, expansion_write_n, pclk_ff}, 4'hE);
    reset_in = 0;
    core_exp_acc = PEB_ACC_NONE;
    hold(4);
    chk("reset cleared", core_reset_ff, 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule
